/* hdl/mcds_cfg.svh */
// offsets, field positions, reset values and timing counts of the block
`ifndef MCDS_CFG_SVH
`define MCDS_CFG_SVH

// register byte addresses on the serial port
`define MCDS_ADDR_DAC_LO   7'h30
`define MCDS_ADDR_DAC_HI   7'h31
`define MCDS_ADDR_MSC_LO   7'h34
`define MCDS_ADDR_MSC_HI   7'h35
`define MCDS_ADDR_GCMD_LO  7'h3e
`define MCDS_ADDR_GCMD_HI  7'h3f

// reset values
`define MCDS_MSC_RST       16'h0000
`define MCDS_DAC_RST       16'h0000

// misc_control field positions
`define MCDS_BIT_LSEL      0
`define MCDS_BIT_POL       1
`define MCDS_BIT_DREN      2
`define MCDS_BIT_STP       8
`define MCDS_BIT_STN       9
`define MCDS_BIT_ST        10
`define MCDS_BIT_MT        11

// global_command latch trigger position
`define MCDS_GCMD_LATCH    2

// writable bits per byte lane
`define MCDS_MSC_LO_MASK   8'h07
`define MCDS_MSC_HI_MASK   8'h0f
`define MCDS_DAC_HI_MASK   8'h0f

// serial frame layout
`define MCDS_FRM_WR        15
`define MCDS_FRM_LAST      5'h0f

// timing
`define MCDS_CLK_NS        4
`define MCDS_DRDY_MIN_US   100
`define MCDS_DRDY_MAX_US   200
`define MCDS_DRDY_CYC  ((`MCDS_DRDY_MIN_US*1000+`MCDS_CLK_NS-1)/`MCDS_CLK_NS)
`define MCDS_ST_SETTLE_MS  50
`define MCDS_ST_SETTLE_CYC ((`MCDS_ST_SETTLE_MS*1000000)/`MCDS_CLK_NS)
`define MCDS_ST_MIN_DELTA  64

`endif

/* hdl/mcds_pkg.sv */
// types shared by the misc control, dac and self-test block
`default_nettype none
package mcds_pkg;
    typedef logic [15:0] mcds_word_t;
    typedef enum logic [1:0] {ST_IDLE, ST_BASE, ST_STIM, ST_DONE} mcds_st_e;
    typedef enum logic {DR_IDLE, DR_PULSE} mcds_dr_e;
endpackage : mcds_pkg
`default_nettype wire

/* hdl/mcds_selftest.sv */
// internal self-test sequencer: baseline, stimulus, measure, decide
`timescale 1ns/1ps
`default_nettype none
module mcds_selftest
    import mcds_pkg::*;
#(
    parameter logic [23:0] SETTLE_CYC = 24'd1,
    parameter logic [15:0] MIN_DELTA  = 16'd1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic [15:0] rate_i,
    output logic             stim_o,
    output logic             done_o,
    output logic             fail_o
);
    mcds_st_e          st_r,   st_nxt;
    logic [23:0]       cnt_r,  cnt_nxt;
    mcds_word_t        base_r, base_nxt;
    logic              stim_r, stim_nxt;
    logic              done_r, done_nxt;
    logic              fail_r, fail_nxt;
    logic signed [16:0] delta_w;

    // response shift relative to the unstimulated baseline
    assign delta_w = $signed({rate_i[15], rate_i})
                   - $signed({base_r[15], base_r});

    // settle, sample baseline, stimulate, settle, judge
    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        base_nxt = base_r;
        stim_nxt = stim_r;
        done_nxt = 1'b0;
        fail_nxt = fail_r;
        case (st_r)
            ST_IDLE: begin
                if (start_i) begin
                    st_nxt  = ST_BASE;
                    cnt_nxt = SETTLE_CYC - 24'd1;
                end
            end
            ST_BASE: begin
                if (cnt_r == 24'd0) begin
                    base_nxt = rate_i;
                    stim_nxt = 1'b1;
                    cnt_nxt  = SETTLE_CYC - 24'd1;
                    st_nxt   = ST_STIM;
                end else begin
                    cnt_nxt = cnt_r - 24'd1;
                end
            end
            ST_STIM: begin
                if (cnt_r == 24'd0) begin
                    fail_nxt = delta_w < $signed({1'b0, MIN_DELTA});
                    stim_nxt = 1'b0;
                    st_nxt   = ST_DONE;
                end else begin
                    cnt_nxt = cnt_r - 24'd1;
                end
            end
            ST_DONE: begin
                done_nxt = 1'b1;
                st_nxt   = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r   <= ST_IDLE;
            cnt_r  <= 24'h000000;
            base_r <= 16'h0000;
            stim_r <= 1'b0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            base_r <= base_nxt;
            stim_r <= stim_nxt;
            done_r <= done_nxt;
            fail_r <= fail_nxt;
        end
    end

    assign stim_o = stim_r;
    assign done_o = done_r;
    assign fail_o = fail_r;
endmodule : mcds_selftest
`default_nettype wire

/* hdl/mcds_top.sv */
// misc control, data-ready pulse, dac code latch and test control block
`include "mcds_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mcds_top
    import mcds_pkg::*;
#(
    parameter logic [23:0] DRDY_CYC      = 24'(`MCDS_DRDY_CYC),
    parameter logic [23:0] ST_SETTLE_CYC = 24'(`MCDS_ST_SETTLE_CYC),
    parameter logic [15:0] ST_MIN_DELTA  = 16'(`MCDS_ST_MIN_DELTA)
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output logic             miso_oe_o,
    input  wire logic        sample_strobe_i,
    input  wire logic [15:0] rate_i,
    input  wire logic        memtest_done_i,
    input  wire logic        memtest_fail_i,
    output logic             memtest_start_o,
    output logic             st_pos_o,
    output logic             st_neg_o,
    output logic             diag_st_fail_o,
    output logic             diag_mt_fail_o,
    output logic [11:0]      dac_code_o,
    output logic             dac_load_o,
    input  wire logic        io_line_one_i,
    output logic             io_line_one_o,
    output logic             io_line_one_oe_o,
    input  wire logic        io_line_two_i,
    output logic             io_line_two_o,
    output logic             io_line_two_oe_o
);
    // ---- link side, on the serial clock ----
    logic        link_rst_n;
    logic [4:0]  bit_cnt_r, bit_cnt_nxt;
    mcds_word_t  rx_r,      rx_nxt;
    mcds_word_t  hold_r,    hold_nxt;
    logic        tgl_r,     tgl_nxt;
    logic        frm_end;
    mcds_word_t  tx_r,      tx_nxt;
    logic        oe_r,      oe_nxt;

    // ---- core side, on clk_i ----
    logic        tgl_s1_r, tgl_s2_r, tgl_s3_r;
    logic        frame_ev;
    logic        wr_w;
    logic [6:0]  addr_w;
    logic [7:0]  dat_w;
    mcds_word_t  msc_r,   msc_nxt;
    mcds_word_t  dac_r,   dac_nxt;
    logic [11:0] dout_r,  dout_nxt;
    logic        dload_r, dload_nxt;
    mcds_word_t  rd_r,    rd_nxt;
    logic        mts_r,   mts_nxt;
    logic        st_go;
    mcds_dr_e    dr_r,    dr_nxt;
    logic [23:0] drc_r,   drc_nxt;
    logic        io1_r,   io1_nxt;
    logic        io1e_r,  io1e_nxt;
    logic        io2_r,   io2_nxt;
    logic        io2e_r,  io2e_nxt;
    logic        stp_r,   stp_nxt;
    logic        stn_r,   stn_nxt;
    logic        dst_r,   dst_nxt;
    logic        dmt_r,   dmt_nxt;
    logic        st_stim;
    logic        st_done;
    logic        st_fail;
    logic        dr_lvl;

    // deselect clears the link shifters between frames
    assign link_rst_n = rst_n_i & ~cs_n_i;
    assign frm_end    = (bit_cnt_r == `MCDS_FRM_LAST);

    // receive shifter, mosi sampled on the rising serial edge
    always_comb begin
        rx_nxt      = {rx_r[14:0], mosi_i};
        bit_cnt_nxt = frm_end ? 5'h00 : bit_cnt_r + 5'h01;
    end

    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_r      <= 16'h0000;
            bit_cnt_r <= 5'h00;
        end else begin
            rx_r      <= rx_nxt;
            bit_cnt_r <= bit_cnt_nxt;
        end
    end

    // whole frame held and flagged by a toggle for the core side
    always_comb begin
        hold_nxt = hold_r;
        tgl_nxt  = tgl_r;
        if (frm_end) begin
            hold_nxt = {rx_r[14:0], mosi_i};
            tgl_nxt  = ~tgl_r;
        end
    end

    always_ff @(posedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_r <= 16'h0000;
            tgl_r  <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
            tgl_r  <= tgl_nxt;
        end
    end

    // transmit shifter: first falling edge loads the read word
    always_comb begin
        oe_nxt = 1'b1;
        if (!oe_r) begin
            tx_nxt = rd_r; // quiet since the previous frame ended
        end else begin
            tx_nxt = {tx_r[14:0], 1'b0};
        end
    end

    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_r <= 16'h0000;
            oe_r <= 1'b0;
        end else begin
            tx_r <= tx_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign miso_o    = tx_r[15];
    assign miso_oe_o = oe_r;

    // toggle synchroniser; only the second and third stages are compared
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
        end else begin
            tgl_s1_r <= tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end

    // frame fields, hold_r has been still for two clk_i edges
    assign frame_ev = tgl_s2_r ^ tgl_s3_r;
    assign wr_w     = hold_r[`MCDS_FRM_WR];
    assign addr_w   = hold_r[14:8];
    assign dat_w    = hold_r[7:0];
    assign st_go    = frame_ev & wr_w & (addr_w == `MCDS_ADDR_MSC_HI)
                    & dat_w[`MCDS_BIT_ST - 8];

    // register writes, self-clearing test bits, dac latch, read data
    always_comb begin
        msc_nxt   = msc_r;
        dac_nxt   = dac_r;
        dout_nxt  = dout_r;
        dload_nxt = 1'b0;
        mts_nxt   = 1'b0;
        rd_nxt    = rd_r;
        if (memtest_done_i) begin
            msc_nxt[`MCDS_BIT_MT] = 1'b0;
        end
        if (st_done) begin
            msc_nxt[`MCDS_BIT_ST] = 1'b0;
        end
        if (frame_ev && wr_w) begin
            case (addr_w)
                `MCDS_ADDR_DAC_LO: begin
                    dac_nxt[7:0] = dat_w;
                end
                `MCDS_ADDR_DAC_HI: begin
                    dac_nxt[15:8] = dat_w & `MCDS_DAC_HI_MASK;
                end
                `MCDS_ADDR_MSC_LO: begin
                    msc_nxt[7:0] = dat_w & `MCDS_MSC_LO_MASK;
                end
                `MCDS_ADDR_MSC_HI: begin
                    // a fresh start outranks a same-cycle completion
                    msc_nxt[15:8] = dat_w & `MCDS_MSC_HI_MASK;
                    mts_nxt = dat_w[`MCDS_BIT_MT - 8];
                end
                `MCDS_ADDR_GCMD_LO: begin
                    if (dat_w[`MCDS_GCMD_LATCH]) begin
                        dout_nxt  = dac_r[11:0];
                        dload_nxt = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (frame_ev && !wr_w) begin
            case ({addr_w[6:1], 1'b0})
                `MCDS_ADDR_DAC_LO: rd_nxt = dac_r;
                `MCDS_ADDR_MSC_LO: rd_nxt = msc_r;
                default:           rd_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            msc_r   <= `MCDS_MSC_RST;
            dac_r   <= `MCDS_DAC_RST;
            dout_r  <= 12'h000;
            dload_r <= 1'b0;
            mts_r   <= 1'b0;
            rd_r    <= 16'h0000;
        end else begin
            msc_r   <= msc_nxt;
            dac_r   <= dac_nxt;
            dout_r  <= dout_nxt;
            dload_r <= dload_nxt;
            mts_r   <= mts_nxt;
            rd_r    <= rd_nxt;
        end
    end

    assign dac_code_o      = dout_r;
    assign dac_load_o      = dload_r;
    assign memtest_start_o = mts_r;

    // data-ready pulse timer, one pulse per sample strobe taken while idle
    always_comb begin
        dr_nxt  = dr_r;
        drc_nxt = drc_r;
        case (dr_r)
            DR_IDLE: begin
                if (sample_strobe_i && msc_r[`MCDS_BIT_DREN]) begin
                    dr_nxt  = DR_PULSE;
                    drc_nxt = DRDY_CYC - 24'd1;
                end
            end
            DR_PULSE: begin
                if (!msc_r[`MCDS_BIT_DREN] || drc_r == 24'd0) begin
                    dr_nxt = DR_IDLE;
                end else begin
                    drc_nxt = drc_r - 24'd1;
                end
            end
            default: dr_nxt = DR_IDLE;
        endcase
    end

    // pin level and drive for the selected io line
    always_comb begin
        dr_lvl   = (dr_nxt == DR_PULSE) ~^ msc_r[`MCDS_BIT_POL];
        io1_nxt  = dr_lvl;
        io2_nxt  = dr_lvl;
        io1e_nxt = msc_r[`MCDS_BIT_DREN] & ~msc_r[`MCDS_BIT_LSEL];
        io2e_nxt = msc_r[`MCDS_BIT_DREN] &  msc_r[`MCDS_BIT_LSEL];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dr_r   <= DR_IDLE;
            drc_r  <= 24'h000000;
            io1_r  <= 1'b0;
            io1e_r <= 1'b0;
            io2_r  <= 1'b0;
            io2e_r <= 1'b0;
        end else begin
            dr_r   <= dr_nxt;
            drc_r  <= drc_nxt;
            io1_r  <= io1_nxt;
            io1e_r <= io1e_nxt;
            io2_r  <= io2_nxt;
            io2e_r <= io2e_nxt;
        end
    end

    assign io_line_one_o    = io1_r;
    assign io_line_one_oe_o = io1e_r;
    assign io_line_two_o    = io2_r;
    assign io_line_two_oe_o = io2e_r;

    // internal self-test sequencer
    mcds_selftest #(
        .SETTLE_CYC (ST_SETTLE_CYC),
        .MIN_DELTA  (ST_MIN_DELTA)
    ) u_selftest (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .start_i (st_go),
        .rate_i  (rate_i),
        .stim_o  (st_stim),
        .done_o  (st_done),
        .fail_o  (st_fail)
    );

    // stimulus drive and diagnostic result flags
    always_comb begin
        stp_nxt = msc_r[`MCDS_BIT_STP] | st_stim;
        stn_nxt = msc_r[`MCDS_BIT_STN];
        dst_nxt = st_done ? st_fail : dst_r;
        dmt_nxt = memtest_done_i ? memtest_fail_i : dmt_r;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stp_r <= 1'b0;
            stn_r <= 1'b0;
            dst_r <= 1'b0;
            dmt_r <= 1'b0;
        end else begin
            stp_r <= stp_nxt;
            stn_r <= stn_nxt;
            dst_r <= dst_nxt;
            dmt_r <= dmt_nxt;
        end
    end

    assign st_pos_o       = stp_r;
    assign st_neg_o       = stn_r;
    assign diag_st_fail_o = dst_r;
    assign diag_mt_fail_o = dmt_r;
endmodule : mcds_top
`default_nettype wire

/* tb/mcds_host_model.sv */
// host serial master: mode 3 frames of sixteen bits
`timescale 1ns/1ps
`default_nettype none
module mcds_host_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    // bus idle: clock high and still, nothing selected
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // one frame msb first: write flag, byte address, data byte
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        cs_n_o = 1'b0;
        #20;
        for (int i = 15; i >= 0; i--) begin
            sclk_o = 1'b0;
            mosi_o = w[i];
            #7.5;
            sclk_o = 1'b1;
            r[i] = miso_i;
            #7.5;
        end
        #20;
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #100;
    endtask : xfer
endmodule : mcds_host_model
`default_nettype wire

/* tb/mcds_top_properties.sv */
// port assertions for the misc control, dac and test block
`timescale 1ns/1ps
`default_nettype none
module mcds_top_properties
    import mcds_pkg::*;
#(
    parameter logic [23:0] DRDY_CYC = 24'd20
) (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        sample_strobe_i,
    input wire logic        memtest_done_i,
    input wire logic        memtest_fail_i,
    input wire logic        memtest_start_o,
    input wire logic        diag_mt_fail_o,
    input wire logic [11:0] dac_code_o,
    input wire logic        dac_load_o,
    input wire logic        io_line_one_o,
    input wire logic        io_line_one_oe_o,
    input wire logic        io_line_two_o,
    input wire logic        io_line_two_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [1:0]  oe, io, mv, lvl_r, on_r, ph_r, ph_nxt;
    logic [23:0] run_r, run_nxt;
    // a move is a level change on a line driven at both edges
    assign oe = {io_line_two_oe_o, io_line_one_oe_o};
    assign io = {io_line_two_o, io_line_one_o};
    assign mv = oe & on_r & (io ^ lvl_r);
    // phase high inside a pulse, run counts steady cycles of line one
    always_comb begin
        ph_nxt  = (ph_r ^ mv) & oe;
        run_nxt = (mv[0] || !oe[0]) ? 24'h0 : run_r + 24'h1;
    end
    // register the trackers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_r <= 2'h0;
            on_r  <= 2'h0;
            ph_r  <= 2'h0;
            run_r <= 24'h0;
        end else begin
            lvl_r <= io;
            on_r  <= oe;
            ph_r  <= ph_nxt;
            run_r <= run_nxt;
        end
    end
    a_pulse_width: assert property (
        mv[0] && ph_r[0] |-> run_r == DRDY_CYC - 24'h1)
        else $error("line one pulse width wrong");
    a_strobe_answer: assert property (
        sample_strobe_i && oe[1] && on_r[1] && !ph_r[1] |-> ##1 mv[1])
        else $error("line two pulse late after strobe");
    a_one_line: assert property (
        !(io_line_one_oe_o && io_line_two_oe_o))
        else $error("both io lines driven");
    a_dac_moves: assert property (
        $changed(dac_code_o) |-> dac_load_o)
        else $error("dac code moved without load");
    a_load_single: assert property (
        dac_load_o |=> !dac_load_o)
        else $error("dac load longer than one cycle");
    a_mt_start: assert property (
        memtest_start_o |=> !memtest_start_o)
        else $error("memory test start longer than one cycle");
    a_mt_result: assert property (
        memtest_done_i |=> diag_mt_fail_o == $past(memtest_fail_i))
        else $error("memory test flag not loaded");
    a_mt_hold: assert property (
        !memtest_done_i |=> $stable(diag_mt_fail_o))
        else $error("memory test flag moved alone");
endmodule : mcds_top_properties
bind mcds_top mcds_top_properties #(
    .DRDY_CYC(DRDY_CYC)
) i_mcds_top_properties (
    .clk_i, .rst_n_i, .sample_strobe_i, .memtest_done_i, .memtest_fail_i,
    .memtest_start_o, .diag_mt_fail_o, .dac_code_o, .dac_load_o,
    .io_line_one_o, .io_line_one_oe_o, .io_line_two_o, .io_line_two_oe_o
);
`default_nettype wire

/* tb/mcds_top_tb.sv */
// bench for the misc control, dac and test block
`timescale 1ns/1ps
`default_nettype none
module mcds_top_tb;
    localparam logic [23:0] DW = 24'd20;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        strobe = 1'b0;
    logic        mt_done = 1'b0;
    logic        mt_fail = 1'b0;
    logic [15:0] rate = 16'h0;
    logic [15:0] delta = 16'h0;
    logic        sclk, cs_n, mosi, miso, miso_oe, miso_w, sel_o;
    logic        mt_start, st_pos, st_neg, st_fail, mt_flag, dac_load;
    logic        io1, io1_oe, io2, io2_oe, io1_w, io2_w;
    logic [11:0] dac_code;
    logic [15:0] r;
    logic [2:0]  cfg = 3'h0;
    logic [1:0]  stim [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    int          fails = 0;
    int          cmp_count = 0;
    int          loads = 0;
    int          starts = 0;
    int          n, k;
    // 250 MHz core clock
    always #2 clk_i = ~clk_i;
    // pull-ups on the io lines, miso floats when released
    assign io1_w  = io1_oe ? io1 : 1'b1;
    assign io2_w  = io2_oe ? io2 : 1'b1;
    assign miso_w = miso_oe ? miso : 1'bz;
    assign sel_o  = cfg[0] ? io2_w : io1_w;
    // sensor at rest, rate rises by delta under positive stimulus
    always @(negedge clk_i) begin
        rate <= st_pos ? delta : 16'h0;
    end
    // count one-cycle latch and memory test start pulses
    always @(negedge clk_i) begin
        if (dac_load === 1'b1) loads++;
        if (mt_start === 1'b1) starts++;
    end
    mcds_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
        .miso_i(miso_w));
    mcds_top #(.DRDY_CYC(DW), .ST_SETTLE_CYC(24'd10)) i_mcds_top (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
        .sample_strobe_i(strobe), .rate_i(rate), .memtest_done_i(mt_done),
        .memtest_fail_i(mt_fail), .memtest_start_o(mt_start),
        .st_pos_o(st_pos), .st_neg_o(st_neg), .diag_st_fail_o(st_fail),
        .diag_mt_fail_o(mt_flag), .dac_code_o(dac_code),
        .dac_load_o(dac_load), .io_line_one_i(io1_w), .io_line_one_o(io1),
        .io_line_one_oe_o(io1_oe), .io_line_two_i(io2_w),
        .io_line_two_o(io2), .io_line_two_oe_o(io2_oe));
    // compare and count
    task automatic chk(input string s, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask : chk
    // write one byte of a register
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] x;
        i_host.xfer({1'b1, a, d}, x);
    endtask : wr
    // read a register; its word comes back in the following frame
    task automatic rdw(input logic [6:0] a, output logic [15:0] v);
        i_host.xfer({1'b0, a, 8'h00}, v);
        i_host.xfer(16'h0000, v);
    endtask : rdw
    task automatic rd(input string s, input logic [6:0] a, logic [15:0] e);
        logic [15:0] v;
        rdw(a, v);
        chk(s, e, v);
    endtask : rd
    // print counts and verdict, end the run
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    // main sequence
    initial begin
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk("idle outputs", 16'h0, {9'h0, io1_oe, io2_oe, st_pos,
            st_neg, dac_load, mt_start, miso_oe});
        rd("misc reset", 7'h34, 16'h0000);
        rd("dac reset", 7'h30, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            cfg = 3'(c);
            wr(7'h34, {5'h1f, cfg});
            rd("misc low", 7'h34, {13'h0, cfg});
            n = {cfg[2] & cfg[0], cfg[2] & ~cfg[0]};
            chk("io enables", 16'(n), {14'h0, io2_oe, io1_oe});
            chk("io idle", 16'(!cfg[1] | !cfg[2]), 16'(sel_o));
            @(negedge clk_i);
            strobe = 1'b1;
            n = 0;
            for (k = 0; k < 40; k++) begin
                @(negedge clk_i);
                strobe = (k == 5);
                if (sel_o === cfg[1]) n++;
            end
            k = cfg[2] ? DW : (cfg[1] ? 40 : 0);
            chk("pulse cycles", 16'(k), 16'(n));
        end
        wr(7'h34, 8'h00);
        wr(7'h36, 8'h01);
        wr(7'h39, 8'h04);
        wr(7'h38, 8'h02);
        rd("unmapped", 7'h38, 16'h0000);
        foreach (stim[i]) begin
            wr(7'h35, {6'h0, stim[i]});
            chk("stimulus", 16'(stim[i]),
                {14'h0, st_neg, st_pos});
        end
        wr(7'h30, 8'hcc);
        wr(7'h31, 8'hfc);
        chk("dac held", 16'h0, {4'h0, dac_code});
        wr(7'h3e, 8'h04);
        chk("dac code", 16'h0ccc, {4'h0, dac_code});
        chk("dac loads", 16'h1, 16'(loads));
        rd("dac reg", 7'h30, 16'h0ccc);
        rd("global command", 7'h3e, 16'h0000);
        wr(7'h35, 8'h08);
        chk("test starts", 16'h1, 16'(starts));
        rd("memory test busy", 7'h34, 16'h0800);
        @(negedge clk_i);
        mt_done = 1'b1;
        mt_fail = 1'b1;
        @(negedge clk_i);
        mt_done = 1'b0;
        mt_fail = 1'b0;
        @(negedge clk_i);
        chk("memory flag", 16'h1, 16'(mt_flag));
        rd("memory test done", 7'h34, 16'h0000);
        for (int t = 0; t < 2; t++) begin
            delta = (t == 0) ? 16'h0040 : 16'h003f;
            wr(7'h35, 8'h04);
            k = 0;
            do begin
                rdw(7'h34, r);
                k++;
            end while (r[10] !== 1'b0 && k < 20);
            chk("self-test busy", 16'h0, r);
            if (r[10] !== 1'b0) conclude();
            chk("self-test flag", 16'(t), 16'(st_fail));
        end
        conclude();
    end
endmodule : mcds_top_tb
`default_nettype wire
